// ### tb_top.sv
/*
  Testbench for the clock reference select top and the PLL model.
  Assumes the register map and masks of the package.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcrs_pkg::*;
  logic i_clock;
  logic i_nrst = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [27:0] line = 28'hAAAAAAA;
  logic [27:0] rec = 28'h5555555;
  logic [27:0] loss = 28'h0000000;
  logic ext = 1'b1;
  logic [15:0] rdata;
  logic pref, ploss, sref, sloss, common, tick1, tick2, bp_en, bp_rs, pll;
  int error_cnt = 0;
  int num_checks = 0;
  tcrs_top tcrs_top_inst (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .i_port_rx_line_clock(line),
    .i_port_recovered_clock(rec), .i_port_loss(loss),
    .i_ext_common_clock(ext), .o_primary_ref_out(pref),
    .o_primary_loss_out(ploss), .o_secondary_ref_out(sref),
    .o_secondary_loss_out(sloss), .o_common_clock(common),
    .o_ts_ref_tick1(tick1), .o_ts_ref_tick2(tick2),
    .o_backplane_sync_enable(bp_en), .o_backplane_resync(bp_rs));
  tcrs_pll_model tcrs_pll_model_inst (.i_clock(i_clock),
    .i_primary_ref(pref), .i_primary_loss(ploss),
    .i_secondary_ref(sref), .i_secondary_loss(sloss), .o_ref(pll));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Tick count over 4096 cycles lies within one of the mean rate
  function automatic logic near(input int n, input int c);
    real x;
    x = 4096.0 * 75937.5 / 40.0e6 * (2.0 ** c);
    near = (n > x - 1.0) && (n < x + 1.0);
  endfunction
  task automatic rates();
    int n1, n2;
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_CMCFG, 16'((c << 9) | ((5 - c) << 6) | 1));
      repeat (4) @(posedge i_clock);
      n1 = 0;
      n2 = 0;
      repeat (4096) begin
        @(posedge i_clock);
        #1;
        n1 += int'(tick1);
        n2 += int'(tick2);
      end
      chk({15'h0000, near(n2, c)}, 16'h0001);
      chk({15'h0000, near(n1, 5 - c)}, 16'h0001);
    end
  endtask
  task automatic bp(input logic [15:0] d, input logic e, input int n);
    int c;
    c = 0;
    wr(ADDR_CMCFG, d);
    repeat (6) begin
      @(posedge i_clock);
      #1;
      c += int'(bp_rs);
    end
    chk({15'h0000, bp_en}, {15'h0000, e});
    chk(16'(c), 16'(n));
  endtask
  task automatic rf(input logic [15:0] s, input logic [27:0] l,
    input logic [4:0] e);
    @(posedge i_clock);
    loss <= l;
    wr(ADDR_SRCSEL, s);
    repeat (10) @(posedge i_clock);
    #1;
    chk({11'h000, pref, ploss, sref, sloss, common}, {11'h000, e});
    chk({15'h0000, pll}, {15'h0000, e[4]});
  endtask
  initial begin
    #2ms;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd(ADDR_CMCFG, CMCFG_RESET);
    rd(ADDR_SRCSEL, SRCSEL_RESET);
    rd(16'h5004, 16'h0000);
    wr(ADDR_CMCFG, 16'hFB7F);
    rd(ADDR_CMCFG, 16'h1B7F);
    wr(ADDR_SRCSEL, 16'hFFFF);
    rd(ADDR_SRCSEL, 16'h0FFF);
    $display("test registers done");
    rates();
    $display("test rates done");
    bp(16'h1001, 1'b1, 1);
    bp(16'h1001, 1'b1, 0);
    bp(16'h0001, 1'b0, 1);
    $display("test backplane done");
    wr(ADDR_CMCFG, 16'h0000);
    rf(16'h0083, 28'h0000000, 5'b10001);
    rf(16'h08A3, 28'h0000000, 5'b00100);
    rf(16'h0083, 28'h000000C, 5'b01010);
    rf(16'h071C, 28'hFFFFFFF, 5'b00000);
    wr(ADDR_CMCFG, 16'h0001);
    rf(16'h071C, 28'hFFFFFFF, 5'b00001);
    $display("test references done");
    print_verdict();
  end
endmodule

// ### tcrs_pkg.sv
/*
  Constants, register map and types for the clock reference select block.
  Assumes a 40 MHz system clock and a 16-bit register port.
*/
// Operation
// - Second rate field selects timestamp clock rate
// - Timestamp ticks come from selected rate
// - Two independent timestamp reference rates
// - Backplane ports sync only while ready
// - Ready toggle restarts backplane port sync
// - Clock management register resets to 0x0001
// - Primary field picks primary ref and loss
// - Bit 5 picks line or recovered clock
// - Primary loss forces recovered clock
// - Secondary field picks secondary ref and loss
// - Secondary loss leaves selection unchanged
// - Source register resets to 0x0000
// - First rate field uses same encoding
// - Common source bit picks common clock origin
package tcrs_pkg;
  localparam int NUM_PORTS = 28;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] ADDR_CMCFG = 16'h5000;
  localparam logic [15:0] ADDR_SRCSEL = 16'h5002;
  localparam logic [15:0] CMCFG_RESET = 16'h0001;
  localparam logic [15:0] SRCSEL_RESET = 16'h0000;
  localparam logic [15:0] CMCFG_MASK = 16'h1FFF;
  localparam logic [15:0] SRCSEL_MASK = 16'h0FFF;
  localparam int CM_COMMON_SRC_BIT = 0;
  localparam int CM_READY_BIT = 12;
  localparam int CM_RATE1_LO = 6;
  localparam int CM_RATE2_LO = 9;
  localparam int SEL_PRI_LO = 0;
  localparam int SEL_SEC_LO = 6;
  localparam int SEL_W = 6;
  localparam int SEL_CLK_BIT = 5;
  localparam logic [4:0] LAST_PORT = 5'h1B;
  localparam int RATE_W = 3;
  localparam int ACC_W = 32;
  localparam real SYS_CLOCK_HZ = 40000000.0;
  localparam real TS_BASE_RATE_HZ = 75937.5;
  localparam logic [ACC_W-1:0] TS_BASE_STEP =
    ACC_W'(longint'(TS_BASE_RATE_HZ / SYS_CLOCK_HZ * 4294967296.0));

  typedef logic [NUM_PORTS-1:0] tcrs_ports_t;

  // Accumulator step for a rate code: base rate doubled per code step
  function automatic logic [ACC_W-1:0] tcrs_rate_step(
    input logic [RATE_W-1:0] code);
    tcrs_rate_step = TS_BASE_STEP << code;
  endfunction

  // Port number valid range check
  function automatic logic tcrs_port_ok(input logic [4:0] port);
    tcrs_port_ok = (port <= LAST_PORT);
  endfunction
endpackage

// ### tcrs_pll_model.sv
/*
  External PLL model fed with the primary and secondary references.
  Assumes registered reference and loss levels on the system clock.
*/
module tcrs_pll_model (
  // Clock
  input wire logic i_clock,
  // References from the block
  input wire logic i_primary_ref,
  input wire logic i_primary_loss,
  input wire logic i_secondary_ref,
  input wire logic i_secondary_loss,
  // Chosen reference
  output logic o_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  // Falls back to secondary while the primary reports loss and the secondary does not
  always_ff @(posedge i_clock) begin
    o_ref <= (i_primary_loss && !i_secondary_loss) ? i_secondary_ref :
      i_primary_ref;
  end
endmodule

// ### tcrs_ref_if.sv
/*
  Interface between the top and one reference selector.
  Assumes the clocks and loss inputs are already synchronised.
*/
interface tcrs_ref_if;
  import tcrs_pkg::*;
  logic [SEL_W-1:0] sel;
  logic los_override;
  tcrs_ports_t line_clock;
  tcrs_ports_t recovered_clock;
  tcrs_ports_t loss;
  logic ref_out;
  logic loss_out;
  modport top (output sel, output los_override, output line_clock,
    output recovered_clock, output loss, input ref_out, input loss_out);
  modport sel_side (input sel, input los_override, input line_clock,
    input recovered_clock, input loss, output ref_out, output loss_out);
endinterface

// ### tcrs_ref_select.sv
/*
  One reference selector: picks a port and its line or recovered clock.
  Assumes synchronised inputs on the same clock; outputs are registered.
*/
module tcrs_ref_select (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Selection and clocks
  tcrs_ref_if.sel_side ref_if
);
  import tcrs_pkg::*;

  typedef struct packed {
    logic ref_out;
    logic loss_out;
  } tcrs_sel_state_t;

  tcrs_sel_state_t state;
  tcrs_sel_state_t next_state;
  logic [4:0] port;
  logic use_recovered;

  always_comb begin
    next_state = state;
    port = ref_if.sel[4:0];
    use_recovered = ref_if.sel[SEL_CLK_BIT];
    if (!tcrs_port_ok(port)) begin
      next_state.ref_out = 1'b0;
      next_state.loss_out = 1'b0;
    end else begin
      if (ref_if.los_override && ref_if.loss[port]) begin
        use_recovered = 1'b1;
      end
      next_state.ref_out = use_recovered ? ref_if.recovered_clock[port]
                                         : ref_if.line_clock[port];
      next_state.loss_out = ref_if.loss[port];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ref_if.ref_out = state.ref_out;
  assign ref_if.loss_out = state.loss_out;
endmodule

// ### tcrs_top.sv
/*
  Clock reference select: config registers, timestamp rate ticks,
  backplane ready control and the two external PLL reference outputs.
  Assumes a 40 MHz clock, a one-cycle strobe register port, and
  asynchronous port clock and loss pins.
*/
// Our own choice: the plain strobed port.
module tcrs_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port
  input wire logic [tcrs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tcrs_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [tcrs_pkg::DATA_W-1:0] o_rdata,
  // Port clocks and loss pins
  input wire logic [tcrs_pkg::NUM_PORTS-1:0] i_port_rx_line_clock,
  input wire logic [tcrs_pkg::NUM_PORTS-1:0] i_port_recovered_clock,
  input wire logic [tcrs_pkg::NUM_PORTS-1:0] i_port_loss,
  input wire logic i_ext_common_clock,
  // External PLL references
  output logic o_primary_ref_out,
  output logic o_primary_loss_out,
  output logic o_secondary_ref_out,
  output logic o_secondary_loss_out,
  // Common clock and timestamp reference ticks
  output logic o_common_clock,
  output logic o_ts_ref_tick1,
  output logic o_ts_ref_tick2,
  // Backplane synchronisation control
  output logic o_backplane_sync_enable,
  output logic o_backplane_resync
);
  import tcrs_pkg::*;

  localparam int SYNC_W = 3 * NUM_PORTS + 1;

  typedef struct packed {
    logic [15:0] cmcfg;
    logic [15:0] srcsel;
    logic [DATA_W-1:0] rdata;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] stable;
    logic ready_prev;
    logic resync;
    logic sync_enable;
    logic [ACC_W-1:0] acc1;
    logic [ACC_W-1:0] acc2;
    logic tick1;
    logic tick2;
    logic common_clock;
    logic primary_ref_out;
    logic pri_loss;
    logic secondary_ref_out;
    logic sec_loss;
  } tcrs_state_t;

  tcrs_state_t state;
  tcrs_state_t next_state;
  tcrs_ref_if pri_if ();
  tcrs_ref_if sec_if ();
  logic [ACC_W:0] sum1;
  logic [ACC_W:0] sum2;
  logic [SYNC_W-1:0] pins;
  tcrs_ports_t sync_line;
  tcrs_ports_t sync_recovered;
  tcrs_ports_t sync_loss;
  logic sync_common;

  assign pins = {i_ext_common_clock, i_port_loss, i_port_recovered_clock,
                 i_port_rx_line_clock};
  assign sync_line = state.stable[NUM_PORTS-1:0];
  assign sync_recovered = state.stable[2*NUM_PORTS-1:NUM_PORTS];
  assign sync_loss = state.stable[3*NUM_PORTS-1:2*NUM_PORTS];
  assign sync_common = state.stable[SYNC_W-1];

  // Primary selector, loss overrides to recovered clock
  assign pri_if.sel = state.srcsel[SEL_PRI_LO +: SEL_W];
  assign pri_if.los_override = 1'b1;
  assign pri_if.line_clock = sync_line;
  assign pri_if.recovered_clock = sync_recovered;
  assign pri_if.loss = sync_loss;

  // Secondary selector, selection kept under loss
  assign sec_if.sel = state.srcsel[SEL_SEC_LO +: SEL_W];
  assign sec_if.los_override = 1'b0;
  assign sec_if.line_clock = sync_line;
  assign sec_if.recovered_clock = sync_recovered;
  assign sec_if.loss = sync_loss;

  tcrs_ref_select u_pri (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .ref_if(pri_if.sel_side)
  );

  tcrs_ref_select u_sec (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .ref_if(sec_if.sel_side)
  );

  always_comb begin
    next_state = state;
    // Pin synchronisers, change taken when stages two and three agree
    next_state.s1 = pins;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (state.s2[i] == state.s3[i]) begin
        next_state.stable[i] = state.s3[i];
      end
    end
    // Register writes
    if (i_wr) begin
      if (i_addr == ADDR_CMCFG) begin
        next_state.cmcfg = i_wdata & CMCFG_MASK;
      end else if (i_addr == ADDR_SRCSEL) begin
        next_state.srcsel = i_wdata & SRCSEL_MASK;
      end
    end
    // Register reads, data in the following cycle
    next_state.rdata = '0;
    if (i_rd) begin
      if (i_addr == ADDR_CMCFG) begin
        next_state.rdata = state.cmcfg & CMCFG_MASK;
      end else if (i_addr == ADDR_SRCSEL) begin
        next_state.rdata = state.srcsel & SRCSEL_MASK;
      end
    end
    // Two independent timestamp reference ticks
    sum1 = {1'b0, state.acc1} +
      {1'b0, tcrs_rate_step(state.cmcfg[CM_RATE1_LO +: RATE_W])};
    sum2 = {1'b0, state.acc2} +
      {1'b0, tcrs_rate_step(state.cmcfg[CM_RATE2_LO +: RATE_W])};
    next_state.acc1 = sum1[ACC_W-1:0];
    next_state.acc2 = sum2[ACC_W-1:0];
    next_state.tick1 = sum1[ACC_W];
    next_state.tick2 = sum2[ACC_W];
    // Backplane ready level and toggle restart pulse
    next_state.ready_prev = state.cmcfg[CM_READY_BIT];
    next_state.sync_enable = state.cmcfg[CM_READY_BIT];
    next_state.resync =
      state.cmcfg[CM_READY_BIT] ^ state.ready_prev;
    // Common clock origin
    next_state.common_clock = state.cmcfg[CM_COMMON_SRC_BIT] ?
      sync_common : pri_if.ref_out;
    // Retime selector outputs
    next_state.primary_ref_out = pri_if.ref_out;
    next_state.pri_loss = pri_if.loss_out;
    next_state.secondary_ref_out = sec_if.ref_out;
    next_state.sec_loss = sec_if.loss_out;
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state <= '0;
      state.cmcfg <= CMCFG_RESET;
      state.srcsel <= SRCSEL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_primary_ref_out = state.primary_ref_out;
  assign o_primary_loss_out = state.pri_loss;
  assign o_secondary_ref_out = state.secondary_ref_out;
  assign o_secondary_loss_out = state.sec_loss;
  assign o_common_clock = state.common_clock;
  assign o_ts_ref_tick1 = state.tick1;
  assign o_ts_ref_tick2 = state.tick2;
  assign o_backplane_sync_enable = state.sync_enable;
  assign o_backplane_resync = state.resync;
endmodule

// ### tcrs_top_asserts.sv
/*
  Checker for the clock reference select top: register port, backplane
  ready control, timestamp ticks and the primary reference selection.
  Assumes a single clock domain and a bind onto tcrs_top.
*/
module tcrs_top_asserts
  import tcrs_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // Pins and outputs
  input wire logic [NUM_PORTS-1:0] i_port_rx_line_clock,
  input wire logic [NUM_PORTS-1:0] i_port_recovered_clock,
  input wire logic [NUM_PORTS-1:0] i_port_loss,
  input wire logic o_primary_ref_out,
  input wire logic o_primary_loss_out,
  input wire logic o_ts_ref_tick1,
  input wire logic o_ts_ref_tick2,
  input wire logic o_backplane_sync_enable,
  input wire logic o_backplane_resync
);
  logic [15:0] cm_s;
  logic [15:0] src_s;
  logic [3:0] quiet;
  logic [3*NUM_PORTS-1:0] pins_q;
  logic [4:0] pp;
  logic pexp;
  assign pp = src_s[4:0];
  assign pexp = (pp <= LAST_PORT) && ((src_s[SEL_CLK_BIT] ||
    i_port_loss[pp]) ? i_port_recovered_clock[pp] :
    i_port_rx_line_clock[pp]);
  // Shadow registers and a count of quiet cycles since any change
  always_ff @(posedge i_clock) begin
    pins_q <= {i_port_loss, i_port_rx_line_clock, i_port_recovered_clock};
    if (!i_nrst) begin
      cm_s <= CMCFG_RESET;
      src_s <= SRCSEL_RESET;
    end else if (i_wr && i_addr == ADDR_CMCFG) begin
      cm_s <= i_wdata & CMCFG_MASK;
    end else if (i_wr && i_addr == ADDR_SRCSEL) begin
      src_s <= i_wdata & SRCSEL_MASK;
    end
    if (!i_nrst || i_wr || pins_q != {i_port_loss, i_port_rx_line_clock,
      i_port_recovered_clock}) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_cm_read_back: assert property (
    $past(i_rd && i_addr == ADDR_CMCFG) |-> o_rdata == $past(cm_s))
    else $error("clock management readback wrong");
  a_src_read_back: assert property (
    $past(i_rd && i_addr == ADDR_SRCSEL) |-> o_rdata == $past(src_s))
    else $error("source select readback wrong");
  a_ready_enable_follows: assert property (
    i_wr && i_addr == ADDR_CMCFG |->
    ##2 o_backplane_sync_enable == $past(i_wdata[CM_READY_BIT], 2))
    else $error("sync enable does not follow ready bit");
  a_resync_on_toggle: assert property (o_backplane_resync ==
    (o_backplane_sync_enable != $past(o_backplane_sync_enable)))
    else $error("resync pulse not tied to ready change");
  a_tick1_single: assert property (
    o_ts_ref_tick1 |=> !o_ts_ref_tick1 [*3])
    else $error("rate one tick too wide");
  a_tick2_single: assert property (
    o_ts_ref_tick2 |=> !o_ts_ref_tick2 [*3])
    else $error("rate two tick too wide");
  a_primary_ref_sel: assert property (
    quiet >= 4'h8 |-> o_primary_ref_out == pexp)
    else $error("primary reference from wrong source");
  c_resync: cover property (o_backplane_resync);
  c_pri_loss: cover property (o_primary_loss_out);
  c_tick2: cover property (o_ts_ref_tick2);
endmodule

bind tcrs_top tcrs_top_asserts tcrs_top_asserts_inst (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_port_rx_line_clock(i_port_rx_line_clock),
  .i_port_recovered_clock(i_port_recovered_clock),
  .i_port_loss(i_port_loss), .o_primary_ref_out(o_primary_ref_out),
  .o_primary_loss_out(o_primary_loss_out),
  .o_ts_ref_tick1(o_ts_ref_tick1), .o_ts_ref_tick2(o_ts_ref_tick2),
  .o_backplane_sync_enable(o_backplane_sync_enable),
  .o_backplane_resync(o_backplane_resync));
